// >>> rtl/ffmd_defs.vh
/*
 Constants for the freefall/motion detector: register offsets, field positions,
 reset values and sample-period timing. Assumes inclusion by bare name.
*/
`ifndef FFMD_DEFS_VH
`define FFMD_DEFS_VH
// ==========================================================
// Register offsets
`define FFMD_ADDR_SOURCE 8'h16
`define FFMD_ADDR_THRESHOLD 8'h17
`define FFMD_ADDR_DEBOUNCE 8'h18
// ==========================================================
// Field positions
`define FFMD_SRC_EVENT_ACTIVE 7
`define FFMD_THS_MODE_BIT 7
`define FFMD_CFG_LATCH 7
`define FFMD_CFG_COMBINE 6
`define FFMD_CFG_Z_EN 5
`define FFMD_CFG_Y_EN 4
`define FFMD_CFG_X_EN 3
// ==========================================================
// Reset values
`define FFMD_THRESHOLD_RESET 8'h00
`define FFMD_DEBOUNCE_RESET 8'h00
// ==========================================================
// Timing: sample step in microseconds for 800 Hz, and the clock rate
`define FFMD_CLK_HZ 100000000
`define FFMD_STEP_800HZ_US 1250
`define FFMD_STEP_800HZ_CYC ((`FFMD_STEP_800HZ_US * (`FFMD_CLK_HZ / 1000000)))
// Threshold scale: 0.063 g per count, 127 counts, so 8 g full range
`define FFMD_THS_MAX 7'h7f
`endif

// >>> rtl/ffmd_sample_tick.v
/*
 Sample-rate tick generator: one-cycle pulse per output sample period.
 Assumes the rate code selects a period in units of the 800 Hz step.
*/
`timescale 1ns/100ps
`include "ffmd_defs.vh"
module ffmd_sample_tick #(
    parameter BASE_CYCLES = `FFMD_STEP_800HZ_CYC
) (
    input wire ref_clk,
    input wire resetn,
    input wire [7:0] step_mult,
    output reg tick
);
    reg [31:0] base_cnt;
    reg [7:0] mult_cnt;
    // ==========================================================
    // Base 1.25 ms divider, then multiple of it per rate and mode
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            base_cnt <= 32'h0;
            mult_cnt <= 8'h0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (base_cnt >= BASE_CYCLES - 1) begin
                base_cnt <= 32'h0;
                if (mult_cnt + 8'h1 >= step_mult) begin
                    mult_cnt <= 8'h0;
                    tick <= 1'b1;
                end else begin
                    mult_cnt <= mult_cnt + 8'h1;
                end
            end else begin
                base_cnt <= base_cnt + 32'h1;
            end
        end
    end
endmodule // ffmd_sample_tick

// >>> rtl/ffmd_axis_compare.v
/*
 One axis comparator: signed 12-bit sample against 7-bit threshold.
 Assumes samples are 8 g full scale, 1 count of threshold = 16 sample counts.
*/
`timescale 1ns/100ps
module ffmd_axis_compare (
    input wire [11:0] sample,
    input wire [6:0] threshold,
    output wire high,
    output wire negative
);
    wire [11:0] mag;
    wire [11:0] ths_scaled;
    assign negative = sample[11];
    assign mag = sample[11] ? (~sample + 12'h001) : sample;
    // Threshold count is 0.063 g; a sample count on the 8 g scale is 1/256 g
    assign ths_scaled = {1'b0, threshold, 4'h0};
    assign high = mag > ths_scaled;
endmodule // ffmd_axis_compare

// >>> rtl/ffmd_detector.v
/*
 Freefall/motion detector with its source, threshold and debounce registers.
 Assumes 8 g scaled 12-bit samples arrive with a valid strobe and that the
 register port is a simple decoded read/write strobe from the serial front end.
*/
`timescale 1ns/100ps
`include "ffmd_defs.vh"
module ffmd_detector #(
    parameter BASE_CYCLES = `FFMD_STEP_800HZ_CYC
) (
    input wire ref_clk,
    input wire resetn,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire [7:0] detect_config_reg,
    input wire detect_irq_enable,
    input wire detect_irq_route,
    input wire [7:0] step_mult,
    input wire sample_valid,
    input wire [11:0] x_sample,
    input wire [11:0] y_sample,
    input wire [11:0] z_sample,
    output reg irq_line1,
    output reg irq_line2,
    output reg [7:0] detect_source_reg,
    output reg event_active
);
    reg [7:0] detect_threshold_reg;
    reg [7:0] detect_debounce_reg;
    reg [7:0] debounce_cnt;
    reg have_sample;
    reg [11:0] x_hold;
    reg [11:0] y_hold;
    reg [11:0] z_hold;
    reg [7:0] next_source;
    reg next_active;
    reg [7:0] next_cnt;
    wire tick;
    wire x_high;
    wire y_high;
    wire z_high;
    wire x_neg;
    wire y_neg;
    wire z_neg;
    wire latch_enable = detect_config_reg[`FFMD_CFG_LATCH];
    wire combine_select = detect_config_reg[`FFMD_CFG_COMBINE];
    wire z_event_enable = detect_config_reg[`FFMD_CFG_Z_EN];
    wire y_event_enable = detect_config_reg[`FFMD_CFG_Y_EN];
    wire x_event_enable = detect_config_reg[`FFMD_CFG_X_EN];
    wire debounce_mode = detect_threshold_reg[`FFMD_THS_MODE_BIT];
    wire [6:0] threshold_value = detect_threshold_reg[6:0];
    wire src_read = reg_rd && (reg_addr == `FFMD_ADDR_SOURCE);
    wire step = tick && have_sample;
    wire cond_motion;
    wire cond_free;
    wire cond;
    wire [7:0] live_flags;
    wire any_enable = x_event_enable | y_event_enable | z_event_enable;

    ffmd_sample_tick #(.BASE_CYCLES(BASE_CYCLES)) u_tick (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .step_mult(step_mult),
        .tick(tick)
    );
    ffmd_axis_compare u_x (
        .sample(x_hold), .threshold(threshold_value), .high(x_high), .negative(x_neg)
    );
    ffmd_axis_compare u_y (
        .sample(y_hold), .threshold(threshold_value), .high(y_high), .negative(y_neg)
    );
    ffmd_axis_compare u_z (
        .sample(z_hold), .threshold(threshold_value), .high(z_high), .negative(z_neg)
    );

    // ==========================================================
    // Helpers
    // Event/polarity pair of one axis; polarity only rides on a detected event
    function [1:0] axis_pair;
        input enable;
        input high;
        input negative;
        begin
            axis_pair = {enable & high, enable & high & negative};
        end
    endfunction

    // Forces the pairs of disabled axes to zero, frozen or live
    function [5:0] axis_mask;
        input [7:0] cfg;
        begin
            axis_mask = {{2{cfg[`FFMD_CFG_Z_EN]}}, {2{cfg[`FFMD_CFG_Y_EN]}},
                         {2{cfg[`FFMD_CFG_X_EN]}}};
        end
    endfunction

    // ==========================================================
    // Combined condition
    assign cond_motion = (x_event_enable & x_high) | (y_event_enable & y_high)
                       | (z_event_enable & z_high);
    // Freefall: every enabled axis low; disabled axes do not veto
    assign cond_free = any_enable & (~x_event_enable | ~x_high)
                     & (~y_event_enable | ~y_high) & (~z_event_enable | ~z_high);
    assign cond = combine_select ? cond_motion : cond_free;
    // Undebounced per-axis flags, forced to zero for disabled axes
    assign live_flags = {1'b0, 1'b0,
                         axis_pair(z_event_enable, z_high, z_neg),
                         axis_pair(y_event_enable, y_high, y_neg),
                         axis_pair(x_event_enable, x_high, x_neg)};

    // ==========================================================
    // Sample capture: latest sample waits for the next step
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            x_hold <= 12'h000;
            y_hold <= 12'h000;
            z_hold <= 12'h000;
            have_sample <= 1'b0;
        end else begin
            if (sample_valid) begin
                x_hold <= x_sample;
                y_hold <= y_sample;
                z_hold <= z_sample;
            end
            if (sample_valid) begin
                have_sample <= 1'b1;
            end else if (step) begin
                have_sample <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Debounce and flag update
    always @* begin
        next_cnt = debounce_cnt;
        next_active = event_active;
        next_source = detect_source_reg;
        if (step) begin
            if (cond) begin
                if (debounce_cnt < detect_debounce_reg) begin
                    next_cnt = debounce_cnt + 8'h01;
                end else begin
                    // A lowered count pulls the counter down so the event can still fire
                    next_cnt = detect_debounce_reg;
                end
            end else if (debounce_mode) begin
                next_cnt = 8'h00;
            end else if (debounce_cnt != 8'h00) begin
                next_cnt = debounce_cnt - 8'h01;
            end
        end
        if (latch_enable) begin
            // Frozen once active; only a source read releases it
            if (!event_active) begin
                next_source = {1'b0, 1'b0, live_flags[5:0]};
                if (step && cond && next_cnt == detect_debounce_reg) begin
                    next_active = 1'b1;
                end
            end
            if (src_read) begin
                next_active = 1'b0;
                next_source = 8'h00;
                next_cnt = 8'h00;
                // A step landing with the read counts as a new event only when the debounce count is zero
                if (step && cond && detect_debounce_reg == 8'h00) begin
                    next_active = 1'b1;
                end
            end
        end else begin
            next_source = {1'b0, 1'b0, live_flags[5:0]};
            if (step) begin
                if (cond && next_cnt == detect_debounce_reg) begin
                    next_active = 1'b1;
                end else if (!cond && (debounce_mode || next_cnt == 8'h00)) begin
                    next_active = 1'b0;
                end
            end
        end
        // Frozen flags too must vanish when their axis is disabled
        next_source[5:0] = next_source[5:0] & axis_mask(detect_config_reg);
        next_source[`FFMD_SRC_EVENT_ACTIVE] = next_active;
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            debounce_cnt <= 8'h00;
            event_active <= 1'b0;
            detect_source_reg <= 8'h00;
        end else begin
            debounce_cnt <= next_cnt;
            event_active <= next_active;
            detect_source_reg <= next_source;
        end
    end

    // ==========================================================
    // Register port
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            detect_threshold_reg <= `FFMD_THRESHOLD_RESET;
            detect_debounce_reg <= `FFMD_DEBOUNCE_RESET;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr) begin
                if (reg_addr == `FFMD_ADDR_THRESHOLD) begin
                    detect_threshold_reg <= reg_wdata;
                end else if (reg_addr == `FFMD_ADDR_DEBOUNCE) begin
                    detect_debounce_reg <= reg_wdata;
                end
            end
            if (reg_rd) begin
                if (reg_addr == `FFMD_ADDR_SOURCE) begin
                    reg_rdata <= detect_source_reg;
                end else if (reg_addr == `FFMD_ADDR_THRESHOLD) begin
                    reg_rdata <= detect_threshold_reg;
                end else if (reg_addr == `FFMD_ADDR_DEBOUNCE) begin
                    reg_rdata <= detect_debounce_reg;
                end else begin
                    reg_rdata <= 8'h00;
                end
            end
        end
    end

    // ==========================================================
    // Interrupt: route 1 selects line 1, 0 selects line 2
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_line1 <= 1'b0;
            irq_line2 <= 1'b0;
        end else begin
            irq_line1 <= next_active & detect_irq_enable & detect_irq_route;
            irq_line2 <= next_active & detect_irq_enable & ~detect_irq_route;
        end
    end
endmodule // ffmd_detector

// >>> verif/ffmd_host.sv
/*
 Host model: single-byte register reads and writes on the detector strobe port.
 Assumes one calling process and the shared reference clock.
*/
`timescale 1ns/100ps
module ffmd_host (
    input wire ref_clk,
    output reg [7:0] reg_addr,
    output reg reg_wr,
    output reg reg_rd,
    output reg [7:0] reg_wdata,
    input wire [7:0] reg_rdata
);
initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
end
// ==========================================================
// Bus cycles
// Released lines carry the inverse so a stale value is never trusted
task wr(input [7:0] a, input [7:0] d);
begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
end
endtask
task rd(input [7:0] a, output [7:0] d);
begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
end
endtask
endmodule // ffmd_host

// >>> verif/ffmd_detector_asserts.sv
/*
 Checker for the detector top, watching its ports only.
 Assumes one clock and a sample tick every BASE_CYCLES*step_mult cycles.
*/
`timescale 1ns/100ps
module ffmd_chk #(
    parameter BASE_CYCLES = 10
) (
    input wire ref_clk,
    input wire resetn,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire [7:0] detect_config_reg,
    input wire [7:0] step_mult,
    input wire sample_valid,
    input wire irq_line1,
    input wire irq_line2,
    input wire [7:0] detect_source_reg,
    input wire event_active
);
// ==========================================================
// Cycles since the last sample; far from one, no evaluation can land
reg [19:0] idle;
wire [31:0] lim = 2 * BASE_CYCLES * (step_mult == 8'h00 ? 1 : step_mult) + 4;
wire quiet = idle > lim[19:0];
wire src_rd = reg_rd && reg_addr == 8'h16;
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) idle <= 20'hfffff;
    else if (sample_valid) idle <= 20'h00000;
    else if (idle != 20'hfffff) idle <= idle + 20'h00001;
end
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!resetn);
// ==========================================================
// Properties
a_event_mirror: assert property (event_active == detect_source_reg[7])
    else $error("event flag and source bit 7 differ");
a_spare_bit: assert property (detect_source_reg[6] == 1'b0)
    else $error("source bit 6 is set");
a_masked_axes: assert property ((detect_config_reg[5] || $past(detect_config_reg[5]) ||
    detect_source_reg[5:4] == 2'b00) && (detect_config_reg[4] || $past(detect_config_reg[4])
    || detect_source_reg[3:2] == 2'b00) && (detect_config_reg[3] ||
    $past(detect_config_reg[3]) || detect_source_reg[1:0] == 2'b00))
    else $error("disabled axis shows a flag");
a_polarity_pair: assert property ((detect_source_reg[4:0] & ~detect_source_reg[5:1] & 5'h15)
    == 5'h00) else $error("polarity set without its event flag");
a_irq_gate: assert property (irq_line1 || irq_line2 |-> event_active && !(irq_line1 && irq_line2))
    else $error("interrupt line without event or on both lines");
a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
a_read_returns: assert property (src_rd |=> reg_rdata == $past(detect_source_reg))
    else $error("source read returned another value");
a_rise_after_sample: assert property ($rose(event_active) |-> idle <= lim[19:0])
    else $error("event rose with no recent sample");
a_read_keeps: assert property (src_rd && !detect_config_reg[7] && quiet
    |=> $stable(detect_source_reg)) else $error("unlatched read changed the source");
a_read_clears: assert property (src_rd && detect_config_reg[7] && quiet
    |=> detect_source_reg == 8'h00 && !irq_line1 && !irq_line2)
    else $error("latched read left flags standing");
c_motion: cover property ($rose(event_active) && detect_config_reg[6]);
c_freefall: cover property ($rose(event_active) && !detect_config_reg[6]);
c_latched_read: cover property (src_rd && detect_config_reg[7] && event_active);
endmodule // ffmd_chk
bind ffmd_detector ffmd_chk #(.BASE_CYCLES(BASE_CYCLES)) u_chk (.ref_clk(ref_clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .detect_config_reg(detect_config_reg), .step_mult(step_mult),
    .sample_valid(sample_valid), .irq_line1(irq_line1), .irq_line2(irq_line2),
    .detect_source_reg(detect_source_reg), .event_active(event_active));

// >>> verif/testbench.sv
/*
 Self-checking bench for the detector: register cycles through the host model
 and sample steps. Assumes a tick every 10*step_mult cycles.
*/
`timescale 1ns/100ps
module testbench;
reg ref_clk = 1'b0;
reg resetn = 1'b0;
reg [7:0] cfg = 8'h00;
reg irq_en = 1'b0;
reg irq_route = 1'b0;
reg [7:0] step_mult = 8'h01;
reg sample_valid = 1'b0;
reg [11:0] xs = 12'h000;
reg [11:0] ys = 12'h000;
reg [11:0] zs = 12'h000;
wire [7:0] reg_addr, reg_wdata, reg_rdata, src;
wire reg_wr, reg_rd, irq_line1, irq_line2, event_active;
integer error_cnt = 0;
integer comparisons = 0;
initial begin
    forever #5 ref_clk = ~ref_clk;
end
ffmd_host u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
ffmd_detector #(.BASE_CYCLES(10)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .detect_config_reg(cfg), .detect_irq_enable(irq_en),
    .detect_irq_route(irq_route), .step_mult(step_mult), .sample_valid(sample_valid),
    .x_sample(xs), .y_sample(ys), .z_sample(zs), .irq_line1(irq_line1),
    .irq_line2(irq_line2), .detect_source_reg(src), .event_active(event_active));
// ==========================================================
// Tasks
task chk(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
begin
    comparisons = comparisons + 1;
    if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
    end
end
endtask
task rdc(input [7:0] a, input [7:0] exp);
reg [7:0] d;
begin
    u_host.rd(a, d);
    chk("register", exp, d);
end
endtask
task rst(input integer n);
begin
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (n) @(posedge ref_clk);
    resetn <= 1'b1;
end
endtask
task setup(input [7:0] c, input [7:0] ths, input [7:0] cnt);
begin
    rst(2);
    cfg <= c;
    u_host.wr(8'h17, ths);
    u_host.wr(8'h18, cnt);
end
endtask
// One sample, then enough cycles for exactly one evaluation of it
task step(input [11:0] x, input [11:0] y, input [11:0] z, input e);
begin
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    xs <= x;
    ys <= y;
    zs <= z;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    repeat (10 * step_mult + 3) @(posedge ref_clk);
    #1;
    chk("event", {7'h00, e}, {7'h00, event_active});
end
endtask
task final_report;
begin
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
        $display("STATUS OK");
    end else begin
        $display("STATUS NOT OK");
    end
    $finish;
end
endtask
// ==========================================================
// Tests
initial begin
    rst(20);
    rdc(8'h17, 8'h00);
    rdc(8'h18, 8'h00);
    rdc(8'h20, 8'h00);
    u_host.wr(8'h16, 8'hff);
    rdc(8'h16, 8'h00);
    u_host.wr(8'h17, 8'h85);
    u_host.wr(8'h18, 8'hff);
    rdc(8'h17, 8'h85);
    rdc(8'h18, 8'hff);
    setup(8'h48, 8'h01, 8'h02);
    irq_en <= 1'b1;
    irq_route <= 1'b1;
    step(12'h020, 12'h000, 12'h000, 1'b0);
    step(12'h020, 12'h000, 12'h000, 1'b1);
    rdc(8'h16, 8'h82);
    rdc(8'h16, 8'h82);
    chk("irq", 8'h02, {6'h00, irq_line1, irq_line2});
    step(12'hfe0, 12'h000, 12'h000, 1'b1);
    rdc(8'h16, 8'h83);
    step(12'h010, 12'h000, 12'h000, 1'b1);
    rdc(8'h16, 8'h80);
    step(12'h010, 12'h000, 12'h000, 1'b0);
    setup(8'h48, 8'h81, 8'h02);
    irq_route <= 1'b0;
    step(12'h020, 12'h000, 12'h000, 1'b0);
    step(12'h020, 12'h000, 12'h000, 1'b1);
    chk("irq", 8'h01, {6'h00, irq_line1, irq_line2});
    step(12'h000, 12'h000, 12'h000, 1'b0);
    step(12'h020, 12'h000, 12'h000, 1'b0);
    setup(8'h38, 8'h01, 8'h00);
    step(12'h005, 12'hffb, 12'h010, 1'b1);
    step(12'h005, 12'h005, 12'h011, 1'b0);
    setup(8'hc8, 8'h01, 8'h02);
    step(12'h020, 12'h000, 12'h000, 1'b0);
    step(12'h020, 12'h000, 12'h000, 1'b1);
    step(12'h000, 12'h000, 12'h000, 1'b1);
    // Let the sample age out so the read cannot meet an evaluation
    repeat (15) @(posedge ref_clk);
    rdc(8'h16, 8'h82);
    rdc(8'h16, 8'h00);
    step(12'h020, 12'h000, 12'h000, 1'b0);
    setup(8'h50, 8'h01, 8'h00);
    step_mult <= 8'h02;
    step(12'h7ff, 12'h000, 12'h000, 1'b0);
    rdc(8'h16, 8'h00);
    step(12'h000, 12'h800, 12'h000, 1'b1);
    rdc(8'h16, 8'h8c);
    final_report;
end
initial begin
    #200000;
    error_cnt = error_cnt + 1;
    final_report;
end
endmodule // testbench
